/* File: include/loop_status_pkg.sv */
// package: constants and types for the loop status and remote control block
package loop_status_pkg;
	localparam int STATUS_W = 8;
	localparam int MASK_PROG_W = 6;
	// status byte bit positions
	localparam int BIT_DATA_READY = 0;
	localparam int BIT_BAD_RANGE = 1;
	localparam int BIT_SYNTAX = 2;
	localparam int BIT_INTERNAL = 3;
	localparam int BIT_PANEL_SRQ = 4;
	localparam int BIT_BAD_CAL = 5;
	localparam int BIT_RQS = 6;
	localparam int BIT_POWER_ON = 7;
	// mask value loaded on clear when the power-on service switch is set (octal 200)
	localparam logic [STATUS_W-1:0] MASK_POWER_ON = 8'h80;
	localparam logic [STATUS_W-1:0] MASK_RESET = 8'h00;
	// bits withdrawn by a serial poll: 2, 4, 5, 7
	localparam logic [STATUS_W-1:0] POLL_CLEAR = 8'hB4;
	localparam logic [STATUS_W-1:0] STATUS_RESET = 8'h00;
	typedef enum logic [1:0] {
		LOC_FREE,
		REM_FREE,
		REM_LOCKED,
		LOC_LOCKED
	} remote_e;
endpackage : loop_status_pkg

/* File: rtl/sticky_bit.sv */
// one latched status bit: set wins over clear
`timescale 1ns/10ps
module sticky_bit (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic set_i,
	input wire logic clr_i,
	// state
	output logic q_o
);
	typedef struct packed {
		logic q;
	} state_s;
	state_s st_q, st_d;
	always_comb begin
		st_d = st_q;
		if (clr_i) begin
			st_d.q = 1'b0;
		end
		// set after clear so an event in the clearing cycle survives
		if (set_i) begin
			st_d.q = 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign q_o = st_q.q;
endmodule : sticky_bit

/* File: rtl/loop_status_remote_control.sv */
// loop message handling, remote/local state and service request status byte
`timescale 1ns/10ps
module loop_status_remote_control
	import loop_status_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// loop messages, one-cycle pulses, and the listen-addressed level
	input wire logic trigger_msg_i,
	input wire logic device_clear_i,
	input wire logic remote_msg_i,
	input wire logic local_msg_i,
	input wire logic lockout_msg_i,
	input wire logic clear_lockout_msg_i,
	input wire logic serial_poll_i,
	input wire logic listen_addressed_i,
	// service mask programming
	input wire logic mask_write_i,
	input wire logic [loop_status_pkg::MASK_PROG_W-1:0] mask_data_i,
	// rear panel switch
	input wire logic power_on_srq_sw_i,
	// front panel buttons, one-cycle pulses
	input wire logic [7:0] panel_buttons_i,
	input wire logic local_button_i,
	input wire logic srq_button_i,
	// measurement engine conditions
	input wire logic reading_ready_i,
	input wire logic data_accept_i,
	input wire logic reading_lost_i,
	input wire logic range_bad_i,
	input wire logic range_good_i,
	input wire logic syntax_error_i,
	input wire logic internal_error_i,
	input wire logic cal_failed_i,
	input wire logic cycle_busy_i,
	// measurement control
	output logic start_cycle_o,
	output logic abort_cycle_o,
	output logic restore_powerup_o,
	output logic [7:0] panel_buttons_o,
	// loop side answers
	output logic srq_o,
	output logic [loop_status_pkg::STATUS_W-1:0] status_byte_o,
	output logic [loop_status_pkg::STATUS_W-1:0] service_mask_o,
	output logic parallel_poll_o,
	output logic controller_active_o,
	// indicators
	output logic remote_indicator_o,
	output logic service_indicator_o,
	output logic lockout_o
);
	typedef struct packed {
		remote_e rmode;
		logic [STATUS_W-1:0] mask;
		logic bad_range;
		logic data_ready;
		logic power_on;
		logic srq_armed;
		logic start;
		logic abort;
		logic restore;
		logic [7:0] buttons;
		logic boot;
		// request term one cycle back, so only a fresh rise re-arms the request
		logic rqs_prev;
	} state_s;

	state_s st_q, st_d;
	logic [STATUS_W-1:0] status_w;
	logic rqs_w;
	logic in_remote_w, locked_w;
	logic local_ok_w, srq_ok_w;
	logic syntax_q_w, internal_q_w, panel_q_w, cal_q_w;

	assign in_remote_w = (st_q.rmode == REM_FREE) || (st_q.rmode == REM_LOCKED);
	assign locked_w = (st_q.rmode == REM_LOCKED) || (st_q.rmode == LOC_LOCKED);
	assign local_ok_w = local_button_i && !(in_remote_w && locked_w);
	assign srq_ok_w = srq_button_i && !(in_remote_w && locked_w);

	// latched event bits, cleared by device clear and, except internal failure, by a serial poll
	sticky_bit u_syntax (
		.clk_i(clk_i), .rst_i(rst_i),
		.set_i(syntax_error_i),
		.clr_i(serial_poll_i || device_clear_i),
		.q_o(syntax_q_w)
	);
	// internal failure is not poll-cleared; it stays until clear or reset
	sticky_bit u_internal (
		.clk_i(clk_i), .rst_i(rst_i),
		.set_i(internal_error_i),
		.clr_i(device_clear_i),
		.q_o(internal_q_w)
	);
	sticky_bit u_panel (
		.clk_i(clk_i), .rst_i(rst_i),
		.set_i(srq_ok_w),
		.clr_i(serial_poll_i || device_clear_i),
		.q_o(panel_q_w)
	);
	sticky_bit u_cal (
		.clk_i(clk_i), .rst_i(rst_i),
		.set_i(cal_failed_i),
		.clr_i(serial_poll_i || device_clear_i),
		.q_o(cal_q_w)
	);

	always_comb begin
		status_w = STATUS_RESET;
		status_w[BIT_DATA_READY] = st_q.data_ready;
		status_w[BIT_BAD_RANGE] = st_q.bad_range;
		status_w[BIT_SYNTAX] = syntax_q_w;
		status_w[BIT_INTERNAL] = internal_q_w;
		status_w[BIT_PANEL_SRQ] = panel_q_w;
		status_w[BIT_BAD_CAL] = cal_q_w;
		status_w[BIT_POWER_ON] = st_q.power_on;
		// bit 6 itself never feeds back into the request term
		rqs_w = |(status_w & st_q.mask);
		status_w[BIT_RQS] = rqs_w;
	end

	always_comb begin
		st_d = st_q;
		st_d.start = 1'b0;
		st_d.abort = 1'b0;
		st_d.restore = 1'b0;
		st_d.boot = 1'b0;
		// power-up: mask follows the switch and the power-on bit is set, caught after reset release
		if (st_q.boot) begin
			st_d.mask = power_on_srq_sw_i ? MASK_POWER_ON : MASK_RESET;
			st_d.power_on = 1'b1;
		end
		if (trigger_msg_i && listen_addressed_i) begin
			st_d.start = 1'b1;
			st_d.abort = cycle_busy_i;
		end
		// remote / local state
		unique case (st_q.rmode)
			LOC_FREE: begin
				if (remote_msg_i) begin
					st_d.rmode = lockout_msg_i ? REM_LOCKED : REM_FREE;
				end else if (lockout_msg_i) begin
					st_d.rmode = LOC_LOCKED;
				end
			end
			REM_FREE: begin
				if (local_msg_i || local_ok_w) begin
					st_d.rmode = LOC_FREE;
				end else if (lockout_msg_i) begin
					st_d.rmode = REM_LOCKED;
				end
			end
			REM_LOCKED: begin
				if (local_msg_i) begin
					st_d.rmode = LOC_LOCKED;
				end
			end
			LOC_LOCKED: begin
				if (remote_msg_i) begin
					st_d.rmode = REM_LOCKED;
				end
			end
		endcase
		if (clear_lockout_msg_i) begin
			st_d.rmode = LOC_FREE;
		end
		// front panel gating
		st_d.buttons = in_remote_w ? 8'h00 : panel_buttons_i;
		// bit 0: accept or loss clears, new reading sets
		if (data_accept_i || reading_lost_i || device_clear_i) begin
			st_d.data_ready = 1'b0;
		end
		if (reading_ready_i) begin
			st_d.data_ready = 1'b1;
		end
		// bit 1 is a level, cleared by a good pairing
		if (range_good_i) begin
			st_d.bad_range = 1'b0;
		end
		if (range_bad_i) begin
			st_d.bad_range = 1'b1;
		end
		if (mask_write_i) begin
			// keep the high bits already decided this cycle, so a write in the boot cycle keeps bit 7
			st_d.mask = {st_d.mask[7:6], mask_data_i};
		end
		// a reason still standing after a poll must not raise the request again
		st_d.rqs_prev = rqs_w;
		if (serial_poll_i) begin
			st_d.srq_armed = 1'b0;
			st_d.power_on = 1'b0;
		end else if (rqs_w && !st_q.srq_armed && !st_q.rqs_prev) begin
			st_d.srq_armed = 1'b1;
		end
		if (!rqs_w) begin
			st_d.srq_armed = 1'b0;
		end
		if (device_clear_i) begin
			st_d.restore = 1'b1;
			st_d.mask = power_on_srq_sw_i ? MASK_POWER_ON : MASK_RESET;
			st_d.bad_range = 1'b0;
			st_d.srq_armed = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.rmode <= LOC_FREE;
			st_q.boot <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign start_cycle_o = st_q.start;
	assign abort_cycle_o = st_q.abort;
	assign restore_powerup_o = st_q.restore;
	assign panel_buttons_o = st_q.buttons;
	assign srq_o = st_q.srq_armed;
	assign status_byte_o = status_w;
	assign service_mask_o = st_q.mask;
	assign parallel_poll_o = 1'b0;
	assign controller_active_o = 1'b0;
	assign remote_indicator_o = in_remote_w;
	assign service_indicator_o = st_q.srq_armed;
	assign lockout_o = locked_w;

	trigger_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(trigger_msg_i && listen_addressed_i) |=> start_cycle_o)
		else $error("trigger did not start a cycle");
	trigger_listen_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(trigger_msg_i && !listen_addressed_i) |=> !start_cycle_o)
		else $error("trigger accepted while not listening");
	clear_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(device_clear_i && !mask_write_i) |=> (service_mask_o == (power_on_srq_sw_i ? 8'h80 : 8'h00)))
		else $error("clear loaded wrong mask");
	remote_buttons_a: assert property (@(posedge clk_i) disable iff (rst_i)
		remote_indicator_o |=> (panel_buttons_o == 8'h00))
		else $error("panel buttons passed in remote");
	lockout_local_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(remote_indicator_o && lockout_o && !local_msg_i && !clear_lockout_msg_i) |=> remote_indicator_o)
		else $error("left remote under lockout");
	clear_lockout_a: assert property (@(posedge clk_i) disable iff (rst_i)
		clear_lockout_msg_i |=> (!lockout_o && !remote_indicator_o))
		else $error("lockout not cancelled");
	rqs_term_a: assert property (@(posedge clk_i) disable iff (rst_i)
		status_byte_o[6] == |(status_byte_o & service_mask_o & 8'hBF))
		else $error("request bit mismatch");
	poll_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(serial_poll_i && !syntax_error_i && !srq_ok_w && !cal_failed_i) |=> ((status_byte_o & 8'hB4) == 8'h00 && !srq_o))
		else $error("poll did not clear bits");
	srq_lamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
		srq_o == service_indicator_o)
		else $error("service lamp mismatch");
	mask_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(mask_write_i && !device_clear_i && !$past(rst_i)) |=> (service_mask_o[7:6] == $past(service_mask_o[7:6])))
		else $error("mask high bits written");
	ready_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(data_accept_i && !reading_ready_i) |=> !status_byte_o[0])
		else $error("data ready not cleared");
	trig_cover: cover property (@(posedge clk_i) trigger_msg_i && listen_addressed_i && cycle_busy_i);
	srq_cover: cover property (@(posedge clk_i) srq_o ##1 serial_poll_i);
	lock_cover: cover property (@(posedge clk_i) remote_indicator_o && lockout_o);
endmodule : loop_status_remote_control

/* File: sim/loop_ctrl_model.sv */
// loop controller model: decoded loop messages, listen addressing and mask writes
`timescale 1ns/10ps
module loop_ctrl_model (
	// clock
	input wire logic clk_i,
	// messages: 0 trigger, 1 clear, 2 remote, 3 local, 4 lockout, 5 clear lockout, 6 poll
	output logic [6:0] msg_o,
	output logic listen_o,
	// mask programming
	output logic mask_write_o,
	output logic [5:0] mask_data_o
);
	initial begin
		msg_o = 7'h00;
		listen_o = 1'b0;
		mask_write_o = 1'b0;
		mask_data_o = 6'h2A;
	end
	task step;
		@(posedge clk_i);
		#1;
	endtask : step
	task send(input int k);
		step;
		msg_o[k] = 1'b1;
		step;
		msg_o[k] = 1'b0;
	endtask : send
	// a trigger is only meant after the device has been addressed to listen
	task listen(input logic v);
		step;
		listen_o = v;
	endtask : listen
	task write_mask(input logic [5:0] d);
		step;
		mask_write_o = 1'b1;
		mask_data_o = d;
		step;
		mask_write_o = 1'b0;
		// released data lines show no stale value
		mask_data_o = ~d;
	endtask : write_mask
endmodule : loop_ctrl_model

/* File: sim/testbench.sv */
// self-checking bench for the loop status and remote control block
`timescale 1ns/10ps
module testbench;
	import loop_status_pkg::*;
	typedef struct {int k; logic [5:0] m; logic rqs;} row_s;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [9:0] ev = 10'h000;
	logic [7:0] btn = 8'h00;
	logic busy = 1'b0;
	logic sw = 1'b0;
	logic [6:0] msg;
	logic [5:0] md;
	logic [7:0] sb, smask, pbo;
	logic lsn, mw, start, abrt, rp, srq, pp, ca, remote_indicator, sind, lko;
	wire m_trig = msg[0], m_clear = msg[1], m_remote = msg[2], m_local = msg[3];
	wire m_lockout = msg[4], m_unlock = msg[5], m_poll = msg[6];
	wire e_ready = ev[0], e_range_bad = ev[1], e_syntax = ev[2], e_internal = ev[3], e_srq_btn = ev[4];
	wire e_cal = ev[5], e_accept = ev[6], e_lost = ev[7], e_range_good = ev[8], e_local_btn = ev[9];
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	// last row: condition true but not masked
	row_s rows [7] = '{'{0, 6'h01, 1'b1}, '{1, 6'h02, 1'b1}, '{2, 6'h04, 1'b1}, '{3, 6'h08, 1'b1},
		'{4, 6'h10, 1'b1}, '{5, 6'h20, 1'b1}, '{0, 6'h10, 1'b0}};
	always #2.5 clk_i = ~clk_i;
	loop_ctrl_model u_ctrl (.clk_i(clk_i), .msg_o(msg), .listen_o(lsn), .mask_write_o(mw), .mask_data_o(md));
	loop_status_remote_control u_dut (.clk_i(clk_i), .rst_i(rst_i), .trigger_msg_i(m_trig),
		.device_clear_i(m_clear), .remote_msg_i(m_remote), .local_msg_i(m_local), .lockout_msg_i(m_lockout),
		.clear_lockout_msg_i(m_unlock), .serial_poll_i(m_poll), .listen_addressed_i(lsn), .mask_write_i(mw),
		.mask_data_i(md), .power_on_srq_sw_i(sw), .panel_buttons_i(btn), .local_button_i(e_local_btn),
		.srq_button_i(e_srq_btn), .reading_ready_i(e_ready), .data_accept_i(e_accept), .reading_lost_i(e_lost),
		.range_bad_i(e_range_bad), .range_good_i(e_range_good), .syntax_error_i(e_syntax),
		.internal_error_i(e_internal), .cal_failed_i(e_cal), .cycle_busy_i(busy), .start_cycle_o(start),
		.abort_cycle_o(abrt),
		.restore_powerup_o(rp), .panel_buttons_o(pbo), .srq_o(srq), .status_byte_o(sb),
		.service_mask_o(smask), .parallel_poll_o(pp), .controller_active_o(ca), .remote_indicator_o(remote_indicator),
		.service_indicator_o(sind), .lockout_o(lko));
	task check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t ns: got %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task step;
		@(posedge clk_i);
		#1;
	endtask : step
	task pulse(input int k);
		step;
		ev[k] = 1'b1;
		step;
		ev[k] = 1'b0;
	endtask : pulse
	task press(input logic [7:0] b, input logic [7:0] exp);
		btn = b;
		step;
		btn = 8'h00;
		check(pbo, exp);
	endtask : press
	task tally_and_finish;
		$display("checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// a hang counts as a failure rather than stalling the run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (20) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		step;
		step;
		check(sb[BIT_POWER_ON], 1'b1);
		check(smask, MASK_RESET);
		check({pp, ca, remote_indicator, lko}, 4'h0);
		u_ctrl.send(6);
		check(sb[BIT_POWER_ON], 1'b0);
		foreach (rows[i]) begin
			u_ctrl.send(1);
			u_ctrl.write_mask(rows[i].m);
			pulse(rows[i].k);
			check(sb[rows[i].k], 1'b1);
			check(sb[BIT_RQS], rows[i].rqs);
			step;
			check({srq, sind}, {2{rows[i].rqs}});
		end
		u_ctrl.send(1);
		u_ctrl.write_mask(6'h07);
		pulse(0);
		pulse(6);
		check(sb[0], 1'b0);
		pulse(0);
		pulse(7);
		check(sb[0], 1'b0);
		pulse(1);
		pulse(8);
		check(sb[1], 1'b0);
		check(sb[BIT_RQS], 1'b0);
		pulse(2);
		pulse(3);
		repeat (5) step;
		check(sb[3:2], 2'b11);
		check(srq, 1'b1);
		u_ctrl.send(6);
		check(sb[3:2], 2'b10);
		check({srq, sb[BIT_RQS]}, 2'b00);
		u_ctrl.listen(1'b0);
		u_ctrl.send(0);
		check({start, abrt}, 2'b00);
		u_ctrl.listen(1'b1);
		u_ctrl.send(0);
		check({start, abrt}, 2'b10);
		busy = 1'b1;
		u_ctrl.send(0);
		check({start, abrt}, 2'b11);
		busy = 1'b0;
		press(8'hA5, 8'hA5);
		u_ctrl.send(2);
		check(remote_indicator, 1'b1);
		press(8'h5A, 8'h00);
		pulse(4);
		check(sb[BIT_PANEL_SRQ], 1'b1);
		u_ctrl.send(6);
		pulse(9);
		check(remote_indicator, 1'b0);
		u_ctrl.send(2);
		u_ctrl.send(4);
		check({remote_indicator, lko}, 2'b11);
		pulse(9);
		pulse(4);
		check({remote_indicator, sb[BIT_PANEL_SRQ]}, 2'b10);
		u_ctrl.send(3);
		check({remote_indicator, lko}, 2'b01);
		u_ctrl.send(2);
		u_ctrl.send(5);
		check({remote_indicator, lko}, 2'b00);
		sw = 1'b1;
		u_ctrl.send(1);
		check(rp, 1'b1);
		check(smask, MASK_POWER_ON);
		u_ctrl.write_mask(6'h3F);
		check(smask, 8'hBF);
		// power cycle in mid-run: lockout must not survive it, bit 7 and its mask come back
		u_ctrl.send(4);
		check(lko, 1'b1);
		rst_i = 1'b1;
		repeat (2) step;
		rst_i = 1'b0;
		step;
		step;
		check({lko, sb[BIT_POWER_ON], srq}, 3'b011);
		check(smask, MASK_POWER_ON);
		// a masked reason that outlives the poll keeps the request bit but not the request
		u_ctrl.write_mask(6'h08);
		pulse(3);
		u_ctrl.send(6);
		repeat (3) step;
		check({srq, sind, sb[BIT_RQS], sb[BIT_INTERNAL]}, 4'h3);
		tally_and_finish();
	end
endmodule : testbench
